// ===== sim/osau_partner.sv
`timescale 1ns/100ps
module osau_partner (
  input  wire logic        clk,
  input  wire logic        ibyte_ready,
  output logic             ibyte_valid,
  output logic [7:0]       ibyte,
  input  wire logic [3:0]  reg_raddr,
  output logic [31:0]      reg_rdata,
  input  wire logic        reg_we,
  input  wire logic [3:0]  reg_waddr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic [3:0]  reg_wbe,
  input  wire logic        mem_req,
  input  wire logic [31:0] mem_addr,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata
);
  logic [31:0] rf [16];
  logic [7:0]  q [$];
  int          dly;
  int          n;

  // ----------------------------------------
  // Register file, byte enables honoured
  // ----------------------------------------
  assign reg_rdata = rf[reg_raddr];
  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (reg_we && reg_wbe[i]) begin
        rf[reg_waddr][8*i+:8] <= reg_wdata[8*i+:8];
      end
    end
  end

  // ----------------------------------------
  // Byte stream; released data toggles
  // ----------------------------------------
  initial begin
    ibyte_valid = 1'b0;
    ibyte = 8'h00;
    mem_ack = 1'b0;
    mem_rdata = 32'h0;
    dly = 0;
    n = 0;
    foreach (rf[i]) rf[i] = 32'h0;
  end
  always @(posedge clk) begin
    if (ibyte_valid && ibyte_ready) begin
      void'(q.pop_front());
    end
    #1;
    if (q.size() > 0) begin
      ibyte_valid = 1'b1;
      ibyte = q[0];
    end else begin
      ibyte_valid = 1'b0;
      ibyte = ~ibyte;
    end
  end

  // ----------------------------------------
  // Memory: pointer word is address xor mask
  // ----------------------------------------
  always @(posedge clk) begin
    #1;
    if (mem_ack || !mem_req) begin
      mem_ack = 1'b0;
      n = 0;
      mem_rdata = ~mem_rdata;
    end else if (n++ >= dly) begin
      mem_ack = 1'b1;
      mem_rdata = mem_addr ^ 32'h5A5A0000;
    end
  end
endmodule // osau_partner

// ===== sim/osau_top_props.sv
`timescale 1ns/100ps
module osau_top_props (
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic        START,
  input wire logic        RES_WE,
  input wire logic [3:0]  RES_REG,
  input wire logic [31:0] RES_DATA,
  input wire logic [1:0]  RES_SIZE,
  input wire logic        IBYTE_VALID,
  input wire logic [7:0]  IBYTE,
  input wire logic        IBYTE_READY,
  input wire logic        REG_WE,
  input wire logic [3:0]  REG_WADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic [3:0]  REG_WBE,
  input wire logic        MEM_REQ,
  input wire logic [31:0] MEM_ADDR,
  input wire logic        MEM_ACK,
  input wire logic        BUSY,
  input wire logic        DONE,
  input wire logic [31:0] OP_ADDR,
  input wire logic        FAULT_RSVD,
  input wire logic        FAULT_ILLEGAL,
  input wire logic        UNPRED,
  input wire logic        UNHANDLED
);
  // ----------------------------------------
  // First specifier byte tracking
  // ----------------------------------------
  logic first_ff;
  logic take1;
  assign take1 = first_ff && IBYTE_VALID && IBYTE_READY;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      first_ff <= 1'b0;
    end else if (START && !BUSY && !RES_WE) begin
      first_ff <= 1'b1;
    end else if (IBYTE_VALID && IBYTE_READY) begin
      first_ff <= 1'b0;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  a_done_pulse: assert property (DONE |=> !DONE && !BUSY)
    else $error("done not a single cycle");
  a_busy_start: assert property (START && !BUSY && !RES_WE |=> BUSY)
    else $error("start not accepted");
  a_ready_busy: assert property (IBYTE_READY |-> BUSY)
    else $error("ready while idle");
  a_mem_hold: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR))
    else $error("memory request dropped early");
  a_mem_release: assert property (MEM_REQ && MEM_ACK |=> !MEM_REQ)
    else $error("memory request held after ack");
  a_res_word: assert property (!BUSY && RES_WE && RES_SIZE == 2'h1 |=> REG_WE && REG_WBE == 4'h3
    && REG_WADDR == $past(RES_REG) && REG_WDATA[15:0] == $past(RES_DATA[15:0]))
    else $error("word result write wrong");
  a_flags_held: assert property (!BUSY && !START |=> $stable({FAULT_RSVD, FAULT_ILLEGAL, UNPRED, OP_ADDR}))
    else $error("status changed while idle");
  a_rsvd_index: assert property (take1 && IBYTE == 8'h4F |-> ##[1:8] DONE && FAULT_RSVD)
    else $error("pc index not faulted");
  a_lit_done: assert property (take1 && IBYTE[7:6] == 2'h0 |-> ##[1:2] DONE && UNHANDLED)
    else $error("literal not handed on");

  c_illegal: cover property (DONE && FAULT_ILLEGAL);
  c_unpred: cover property (DONE && UNPRED);
  c_mem: cover property (MEM_REQ && MEM_ACK);
  c_word: cover property (REG_WE && REG_WBE == 4'h3);
endmodule // osau_top_props

bind osau_top osau_top_props u_props (.*);

// ===== sim/osau_top_test.sv
`timescale 1ns/100ps
module osau_top_test;
  logic        clk, rst_n, start, ibyte_valid, ibyte_ready, reg_we, res_we;
  logic        mem_req, mem_ack, busy, done, fault_rsvd, fault_illegal, unpred, unhandled;
  logic [2:0]  ctx;
  logic [7:0]  ibyte;
  logic [3:0]  reg_raddr, reg_waddr, reg_wbe, res_reg, flg;
  logic [1:0]  res_size;
  logic [31:0] pc_start, reg_rdata, reg_wdata, res_data, mem_addr, mem_rdata, op_addr, pc_next;
  int          err_count, checked;
  assign flg = {fault_rsvd, fault_illegal, unpred, unhandled};

  osau_top uut (.CLK(clk), .RST_N(rst_n), .START(start), .CTX(ctx), .PC_START(pc_start),
    .IBYTE_VALID(ibyte_valid), .IBYTE(ibyte), .IBYTE_READY(ibyte_ready), .REG_RADDR(reg_raddr),
    .REG_RDATA(reg_rdata), .REG_WE(reg_we), .REG_WADDR(reg_waddr), .REG_WDATA(reg_wdata),
    .REG_WBE(reg_wbe), .RES_WE(res_we), .RES_REG(res_reg), .RES_DATA(res_data), .RES_SIZE(res_size),
    .MEM_REQ(mem_req), .MEM_ADDR(mem_addr), .MEM_ACK(mem_ack), .MEM_RDATA(mem_rdata), .BUSY(busy),
    .DONE(done), .OP_ADDR(op_addr), .PC_NEXT(pc_next), .FAULT_RSVD(fault_rsvd),
    .FAULT_ILLEGAL(fault_illegal), .UNPRED(unpred), .UNHANDLED(unhandled));
  osau_partner p (.*);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  task go(input logic [2:0] c, input logic [31:0] pc);
    int k;
    @(posedge clk);
    #1 start = 1'b1;
    ctx = c;
    pc_start = pc;
    @(posedge clk);
    #1 start = 1'b0;
    for (k = 0; k < 200 && done !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    if (k == 200) chk("done", 32'h0, 32'h1);
    @(posedge clk);
    #1 p.q.delete();
  endtask

  task wr(input logic [1:0] sz, input logic [31:0] d);
    @(posedge clk);
    #1 res_we = 1'b1;
    res_reg = 4'h7;
    res_size = sz;
    res_data = d;
    @(posedge clk);
    #1 res_we = 1'b0;
    @(posedge clk);
    #1;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_disp;
    p.rf[2] = 32'h1000;
    p.q = '{8'hA2, 8'hFE};
    go(osau_pkg::CTX_LONG, 32'h0);
    chk("bdisp", op_addr, 32'h0FFE);
    p.q = '{8'hC2, 8'h00, 8'h80};
    go(osau_pkg::CTX_LONG, 32'h0);
    chk("wdisp", op_addr, 32'hFFFF9000);
    p.q = '{8'hE2, 8'h78, 8'h56, 8'h34, 8'h12};
    go(osau_pkg::CTX_LONG, 32'h0);
    chk("ldisp", op_addr, 32'h12346678);
    $display("test disp done");
  endtask

  task t_auto;
    p.rf[3] = 32'h2000;
    p.q = '{8'h73};
    go(osau_pkg::CTX_LONG, 32'h0);
    chk("autodec op", op_addr, 32'h1FFC);
    chk("autodec reg", p.rf[3], 32'h1FFC);
    p.q = '{8'h83};
    go(osau_pkg::CTX_WORD, 32'h0);
    chk("inc op", op_addr, 32'h1FFC);
    chk("inc reg", p.rf[3], 32'h1FFE);
    p.dly = 3;
    p.q = '{8'h93};
    go(osau_pkg::CTX_BYTE, 32'h0);
    chk("incdef op", op_addr, 32'h5A5A1FFE);
    chk("incdef reg", p.rf[3], 32'h2002);
    p.dly = 0;
    p.q = '{8'hB3, 8'h02};
    go(osau_pkg::CTX_LONG, 32'h0);
    chk("dispdef", op_addr, 32'h5A5A2004);
    $display("test auto done");
  endtask

  task t_pc;
    p.q = '{8'h8F, 8'h11, 8'h22, 8'h33, 8'h44};
    go(osau_pkg::CTX_LONG, 32'h3000);
    chk("imm op", op_addr, 32'h3001);
    chk("imm pc", pc_next, 32'h3005);
    p.q = '{8'h9F, 8'h78, 8'h56, 8'h34, 8'h12};
    go(osau_pkg::CTX_LONG, 32'h3000);
    chk("abs", op_addr, 32'h12345678);
    p.q = '{8'hAF, 8'h10};
    go(osau_pkg::CTX_LONG, 32'h3000);
    chk("rel", op_addr, 32'h3012);
    p.q = '{8'hBF, 8'h10};
    go(osau_pkg::CTX_LONG, 32'h3000);
    chk("reldef", op_addr, 32'h5A5A3012);
    p.q = '{8'h7F};
    go(osau_pkg::CTX_LONG, 32'h3000);
    chk("pc autodec", 32'(flg), 32'h2);
    $display("test pc done");
  endtask

  task t_bad;
    p.q = '{8'h45, 8'h52};
    go(osau_pkg::CTX_LONG, 32'h0);
    chk("reg base", 32'(flg), 32'h4);
    p.q = '{8'h45, 8'h05};
    go(osau_pkg::CTX_LONG, 32'h0);
    chk("lit base", 32'(flg), 32'h4);
    p.q = '{8'h45, 8'h45, 8'h62};
    go(osau_pkg::CTX_LONG, 32'h0);
    chk("idx base", 32'(flg), 32'h4);
    p.q = '{8'h4F, 8'h62};
    go(osau_pkg::CTX_LONG, 32'h0);
    chk("pc index", 32'(flg), 32'h8);
    p.q = '{8'h45, 8'h85};
    go(osau_pkg::CTX_LONG, 32'h0);
    chk("same reg", 32'(flg), 32'h2);
    p.q = '{8'h45, 8'h7F};
    go(osau_pkg::CTX_LONG, 32'h0);
    chk("pc autodec base", 32'(flg), 32'h2);
    p.q = '{8'h52};
    go(osau_pkg::CTX_LONG, 32'h0);
    chk("reg primary", 32'(flg), 32'h1);
    p.q = '{8'h05};
    go(osau_pkg::CTX_LONG, 32'h0);
    chk("lit primary", 32'(flg), 32'h1);
    $display("test bad done");
  endtask

  task t_index;
    p.rf[1] = 32'h1000;
    p.rf[2] = 32'h1000;
    p.rf[5] = 32'h3;
    for (int c = 0; c < 5; c++) begin
      p.q = '{8'h45, 8'h62};
      go(3'(c), 32'h0);
      chk("index", op_addr, 32'h1000 + (32'h3 << c));
      chk("index ok", 32'(flg), 32'h0);
    end
    p.q = '{8'h45, 8'hB1, 8'h10};
    go(osau_pkg::CTX_LONG, 32'h0);
    chk("index def", op_addr, 32'h5A5A101C);
    $display("test index done");
  endtask

  task t_word;
    p.rf[7] = 32'hAABBCCDD;
    wr(2'h1, 32'h11223344);
    chk("word res", p.rf[7], 32'hAABB3344);
    wr(2'h0, 32'h99887755);
    chk("byte res", p.rf[7], 32'hAABB3355);
    wr(2'h2, 32'h01020304);
    chk("long res", p.rf[7], 32'h01020304);
    $display("test word done");
  endtask

  task print_verdict;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #200000;
    err_count++;
    print_verdict;
  end

  initial begin
    {rst_n, start, res_we, ctx, res_reg, res_size} = '0;
    pc_start = 32'h0;
    res_data = 32'h0;
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    t_disp;
    t_auto;
    t_pc;
    t_bad;
    t_index;
    t_word;
    print_verdict;
  end
endmodule // osau_top_test

// ===== verilog/osau_dec_if.sv
`timescale 1ns/100ps
interface osau_split_if;
  logic [7:0] spec;
  logic [3:0] mode;
  logic [3:0] rnum;
  logic       is_lit;
  logic       is_reg;
  logic       is_index;
  logic       modifies;
  logic [4:0] disp_len;

  modport split (input spec, output mode, rnum, is_lit, is_reg, is_index, modifies, disp_len);
  modport use_side (output spec, input mode, rnum, is_lit, is_reg, is_index, modifies, disp_len);
endinterface

// ===== verilog/osau_pkg.sv
package osau_pkg;

  // ----------------------------------------------------------------
  // Specifier byte layout
  // ----------------------------------------------------------------
  localparam int        SPEC_MODE_HI   = 7;
  localparam int        SPEC_MODE_LO   = 4;
  localparam int        SPEC_REG_HI    = 3;
  localparam int        SPEC_REG_LO    = 0;

  // ----------------------------------------------------------------
  // Addressing mode codes
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_INDEX     = 4'h4;
  localparam logic [3:0] MODE_REG       = 4'h5;
  localparam logic [3:0] MODE_REGDEF    = 4'h6;
  localparam logic [3:0] MODE_AUTODEC   = 4'h7;
  localparam logic [3:0] MODE_AUTOINC   = 4'h8;
  localparam logic [3:0] MODE_AUTOINCDF = 4'h9;
  localparam logic [3:0] MODE_BDISP     = 4'hA;
  localparam logic [3:0] MODE_WDISP     = 4'hC;
  localparam logic [3:0] MODE_LDISP     = 4'hE;
  localparam logic [3:0] REG_PC         = 4'hF;

  // ----------------------------------------------------------------
  // Sizes, context codes and byte enables
  // ----------------------------------------------------------------
  localparam logic [2:0]  CTX_BYTE      = 3'h0;
  localparam logic [2:0]  CTX_WORD      = 3'h1;
  localparam logic [2:0]  CTX_LONG      = 3'h2;
  localparam logic [2:0]  CTX_QUAD      = 3'h3;
  localparam logic [2:0]  CTX_OCTA      = 3'h4;
  localparam logic [4:0]  DISP_LEN_B    = 5'h1;
  localparam logic [4:0]  DISP_LEN_W    = 5'h2;
  localparam logic [4:0]  DISP_LEN_L    = 5'h4;
  localparam logic [31:0] PTR_BYTES     = 32'h4;
  localparam logic [1:0]  RES_SZ_BYTE   = 2'h0;
  localparam logic [1:0]  RES_SZ_WORD   = 2'h1;
  localparam logic [3:0]  WBE_BYTE      = 4'h1;
  localparam logic [3:0]  WBE_WORD      = 4'h3;
  localparam logic [3:0]  WBE_LONG      = 4'hF;

  // ----------------------------------------------------------------
  // Shared arithmetic
  // ----------------------------------------------------------------
  function automatic logic [31:0] osau_sext(input logic [31:0] v, input logic [4:0] len);
    unique case (len)
      DISP_LEN_B: osau_sext = {{24{v[7]}}, v[7:0]};
      DISP_LEN_W: osau_sext = {{16{v[15]}}, v[15:0]};
      default:    osau_sext = v;
    endcase
  endfunction

  function automatic logic [4:0] osau_size(input logic [2:0] ctx);
    osau_size = 5'(5'h1 << ctx);
  endfunction

  function automatic logic [3:0] osau_wbe(input logic [1:0] sz);
    unique case (sz)
      RES_SZ_BYTE: osau_wbe = WBE_BYTE;
      RES_SZ_WORD: osau_wbe = WBE_WORD;
      default:     osau_wbe = WBE_LONG;
    endcase
  endfunction

endpackage

// ===== verilog/osau_spec_dec.sv
`timescale 1ns/100ps
module osau_spec_split (
  osau_split_if.split d
);

  // ----------------------------------------------------------------
  // Specifier byte split
  // ----------------------------------------------------------------
  // RULE19: mode high, register low
  assign d.mode     = d.spec[osau_pkg::SPEC_MODE_HI:osau_pkg::SPEC_MODE_LO];
  assign d.rnum     = d.spec[osau_pkg::SPEC_REG_HI:osau_pkg::SPEC_REG_LO];
  assign d.is_lit   = (d.mode[3:2] == 2'h0);
  assign d.is_index = (d.mode == osau_pkg::MODE_INDEX);
  assign d.is_reg   = (d.mode == osau_pkg::MODE_REG);
  assign d.modifies = (d.mode == osau_pkg::MODE_AUTODEC) || (d.mode == osau_pkg::MODE_AUTOINC) ||
                      (d.mode == osau_pkg::MODE_AUTOINCDF);

  // RULE8: byte, word or longword displacement
  always_comb begin
    unique case (d.mode[2:1])
      2'h1:    d.disp_len = osau_pkg::DISP_LEN_B;
      2'h2:    d.disp_len = osau_pkg::DISP_LEN_W;
      default: d.disp_len = osau_pkg::DISP_LEN_L;
    endcase
  end

endmodule // osau_spec_split

// ===== verilog/osau_top.sv
//
// Contract
// RULE1: Autodecrement subtracts operand size, writes register back, uses reduced value.
// RULE2: Autodecrement on program counter gives unpredictable address and flag.
// RULE3: Autoincrement uses register as address, then advances it by size.
// RULE4: Autoincrement on program counter is immediate, operand taken from stream.
// RULE5: Autoincrement deferred fetches pointer longword, then advances register by four.
// RULE6: Autoincrement deferred on program counter is absolute mode.
// RULE7: Word result writes replace only the low half of a register.
// RULE8: Displacement of 8, 16 or 32 bits, sign-extended, added to register.
// RULE9: Displacement on program counter is relative mode.
// RULE10: Displacement deferred reads longword at sum; contents are operand address.
// RULE11: Displacement deferred on program counter is relative deferred mode.
// RULE12: Index value shifted left by data-type context, zero to four.
// RULE13: Index specifier: mode 4 plus index register, then base specifier byte.
// RULE14: Indexed address is evaluated base address plus scaled index.
// RULE15: Register, literal or index base raises illegal addressing mode fault.
// RULE16: Base faults or unpredictability carry over unchanged under index mode.
// RULE17: Program counter as index register raises reserved addressing mode fault.
// RULE18: Modifying base on the index register makes the address unpredictable.
// RULE19: Specifier byte: mode in upper nibble, register in lower nibble.
//
`timescale 1ns/100ps
module osau_top (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        START,
  input  wire logic [2:0]  CTX,
  input  wire logic [31:0] PC_START,
  input  wire logic        IBYTE_VALID,
  input  wire logic [7:0]  IBYTE,
  output logic             IBYTE_READY,
  output logic [3:0]       REG_RADDR,
  input  wire logic [31:0] REG_RDATA,
  output logic             REG_WE,
  output logic [3:0]       REG_WADDR,
  output logic [31:0]      REG_WDATA,
  output logic [3:0]       REG_WBE,
  input  wire logic        RES_WE,
  input  wire logic [3:0]  RES_REG,
  input  wire logic [31:0] RES_DATA,
  input  wire logic [1:0]  RES_SIZE,
  output logic             MEM_REQ,
  output logic [31:0]      MEM_ADDR,
  input  wire logic        MEM_ACK,
  input  wire logic [31:0] MEM_RDATA,
  output logic             BUSY,
  output logic             DONE,
  output logic [31:0]      OP_ADDR,
  output logic [31:0]      PC_NEXT,
  output logic             FAULT_RSVD,
  output logic             FAULT_ILLEGAL,
  output logic             UNPRED,
  output logic             UNHANDLED
);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_SPEC, ST_REGRD, ST_DISP, ST_MEMRD, ST_IDXRD} osau_state_e;
  typedef enum logic [1:0] {K_DISP, K_IMM, K_ABS} osau_kind_e;

  typedef struct packed {
    osau_state_e st;
    osau_kind_e  kind;
    logic [2:0]  ctx;
    logic [31:0] pc;
    logic        in_idx;
    logic [3:0]  xreg;
    logic [3:0]  mode;
    logic [3:0]  rnum;
    logic [31:0] base;
    logic [31:0] acc;
    logic [4:0]  cnt;
    logic [4:0]  need;
    logic        defer;
    logic        pend_wb;
    logic [31:0] wb_val;
    logic        ibyte_ready;
    logic [3:0]  reg_raddr;
    logic        reg_we;
    logic [3:0]  reg_waddr;
    logic [31:0] reg_wdata;
    logic [3:0]  reg_wbe;
    logic        mem_req;
    logic [31:0] mem_addr;
    logic        busy;
    logic        done;
    logic [31:0] addr;
    logic        fault_rsvd;
    logic        fault_ill;
    logic        unpred;
    logic        unhandled;
  } osau_state_s;

  osau_state_s q;
  osau_state_s n;
  logic        rst_n_meta_ff;
  logic        rst_n_ff;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_n_meta_ff <= 1'b0;
      rst_n_ff      <= 1'b0;
    end else begin
      rst_n_meta_ff <= 1'b1;
      rst_n_ff      <= rst_n_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // Specifier decode
  // ----------------------------------------------------------------
  osau_split_if dif ();

  assign dif.spec = IBYTE;

  osau_spec_split u_split (
    .d (dif.split)
  );

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  logic [31:0] base_val;
  logic [31:0] size_val;
  logic [31:0] acc_new;
  logic [31:0] pc_inc;
  logic [31:0] disp_sum;
  logic [4:0]  cnt_inc;
  logic        post;
  logic        fin;

  always_comb begin
    n        = q;
    n.reg_we = 1'b0;
    n.done   = 1'b0;
    post     = 1'b0;
    fin      = 1'b0;
    base_val = (q.rnum == osau_pkg::REG_PC) ? q.pc : REG_RDATA;
    size_val = 32'(osau_pkg::osau_size(q.ctx));
    pc_inc   = q.pc + 32'h1;
    cnt_inc  = q.cnt + 5'h1;
    acc_new  = q.acc | (32'(IBYTE) << {q.cnt[1:0], 3'h0});
    disp_sum = ((q.rnum == osau_pkg::REG_PC) ? pc_inc : q.base) + osau_pkg::osau_sext(acc_new, q.need);

    unique case (q.st)
      ST_IDLE: begin
        if (RES_WE) begin
          // RULE7: byte-enabled result write
          n.reg_we    = 1'b1;
          n.reg_waddr = RES_REG;
          n.reg_wdata = RES_DATA;
          n.reg_wbe   = osau_pkg::osau_wbe(RES_SIZE);
        end else if (START) begin
          n.ctx         = CTX;
          n.pc          = PC_START;
          n.in_idx      = 1'b0;
          n.pend_wb     = 1'b0;
          n.fault_rsvd  = 1'b0;
          n.fault_ill   = 1'b0;
          n.unpred      = 1'b0;
          n.unhandled   = 1'b0;
          n.ibyte_ready = 1'b1;
          n.st          = ST_SPEC;
        end
      end

      ST_SPEC: begin
        if (IBYTE_VALID) begin
          n.pc = pc_inc;
          if (q.in_idx && (dif.is_lit || dif.is_reg || dif.is_index)) begin
            // RULE15: bad base under index
            n.fault_ill = 1'b1;
            fin         = 1'b1;
          end else if (dif.is_index) begin
            if (dif.rnum == osau_pkg::REG_PC) begin
              // RULE17: pc as index register
              n.fault_rsvd = 1'b1;
              fin          = 1'b1;
            end else begin
              // RULE13: base byte follows
              n.in_idx = 1'b1;
              n.xreg   = dif.rnum;
            end
          end else if (dif.is_lit || dif.is_reg) begin
            n.unhandled = 1'b1;
            fin         = 1'b1;
          end else begin
            // RULE18: base modifies index register
            n.unpred      = q.in_idx && dif.modifies && (dif.rnum == q.xreg);
            n.mode        = dif.mode;
            n.rnum        = dif.rnum;
            n.reg_raddr   = dif.rnum;
            n.need        = dif.disp_len;
            n.ibyte_ready = 1'b0;
            n.st          = ST_REGRD;
          end
        end
      end

      ST_REGRD: begin
        n.base = base_val;
        n.acc  = 32'h0;
        n.cnt  = 5'h0;
        n.kind = K_DISP;
        // RULE16: same checks apply under index
        unique case (q.mode)
          osau_pkg::MODE_REGDEF: begin
            n.addr = base_val;
            post   = 1'b1;
          end
          osau_pkg::MODE_AUTODEC: begin
            // RULE2: pc makes result unpredictable
            if (q.rnum == osau_pkg::REG_PC) begin
              n.unpred = 1'b1;
            end
            // RULE1: predecrement and write back
            n.addr      = base_val - size_val;
            n.reg_we    = 1'b1;
            n.reg_waddr = q.rnum;
            n.reg_wdata = base_val - size_val;
            n.reg_wbe   = osau_pkg::WBE_LONG;
            post        = 1'b1;
          end
          osau_pkg::MODE_AUTOINC: begin
            if (q.rnum == osau_pkg::REG_PC) begin
              // RULE4: immediate, skip operand bytes
              n.addr        = q.pc;
              n.kind        = K_IMM;
              n.need        = osau_pkg::osau_size(q.ctx);
              n.ibyte_ready = 1'b1;
              n.st          = ST_DISP;
            end else begin
              // RULE3: address then postincrement
              n.addr      = base_val;
              n.reg_we    = 1'b1;
              n.reg_waddr = q.rnum;
              n.reg_wdata = base_val + size_val;
              n.reg_wbe   = osau_pkg::WBE_LONG;
              post        = 1'b1;
            end
          end
          osau_pkg::MODE_AUTOINCDF: begin
            if (q.rnum == osau_pkg::REG_PC) begin
              // RULE6: absolute address from stream
              n.kind        = K_ABS;
              n.need        = osau_pkg::DISP_LEN_L;
              n.ibyte_ready = 1'b1;
              n.st          = ST_DISP;
            end else begin
              // RULE5: fetch pointer, then add four
              n.mem_req  = 1'b1;
              n.mem_addr = base_val;
              n.pend_wb  = 1'b1;
              n.wb_val   = base_val + osau_pkg::PTR_BYTES;
              n.st       = ST_MEMRD;
            end
          end
          default: begin
            n.defer       = q.mode[0];
            n.ibyte_ready = 1'b1;
            n.st          = ST_DISP;
          end
        endcase
      end

      ST_DISP: begin
        if (IBYTE_VALID) begin
          n.pc  = pc_inc;
          n.acc = acc_new;
          n.cnt = cnt_inc;
          if (cnt_inc == q.need) begin
            n.ibyte_ready = 1'b0;
            unique case (q.kind)
              K_IMM: begin
                post = 1'b1;
              end
              K_ABS: begin
                n.addr = acc_new;
                post   = 1'b1;
              end
              default: begin
                // RULE8: sign-extend and add
                // RULE9: pc base is pc after displacement
                // RULE11: pc deferred is relative deferred
                if (q.defer) begin
                  // RULE10: fetch operand address
                  n.mem_req  = 1'b1;
                  n.mem_addr = disp_sum;
                  n.st       = ST_MEMRD;
                end else begin
                  n.addr = disp_sum;
                  post   = 1'b1;
                end
              end
            endcase
          end
        end
      end

      ST_MEMRD: begin
        if (MEM_ACK) begin
          n.mem_req = 1'b0;
          n.addr    = MEM_RDATA;
          if (q.pend_wb) begin
            // RULE5: advance after fetch
            n.pend_wb   = 1'b0;
            n.reg_we    = 1'b1;
            n.reg_waddr = q.rnum;
            n.reg_wdata = q.wb_val;
            n.reg_wbe   = osau_pkg::WBE_LONG;
          end
          post = 1'b1;
        end
      end

      ST_IDXRD: begin
        // RULE12: context-scaled index
        // RULE14: base plus scaled index
        n.addr = q.addr + (REG_RDATA << q.ctx);
        fin    = 1'b1;
      end

      default: begin
        fin = 1'b1;
      end
    endcase

    if (post) begin
      if (q.in_idx) begin
        n.reg_raddr = q.xreg;
        n.st        = ST_IDXRD;
      end else begin
        fin = 1'b1;
      end
    end

    if (fin) begin
      n.done        = 1'b1;
      n.ibyte_ready = 1'b0;
      n.mem_req     = 1'b0;
      n.st          = ST_IDLE;
    end
    n.busy = (n.st != ST_IDLE);
  end

  always_ff @(posedge CLK or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign IBYTE_READY   = q.ibyte_ready;
  assign REG_RADDR     = q.reg_raddr;
  assign REG_WE        = q.reg_we;
  assign REG_WADDR     = q.reg_waddr;
  assign REG_WDATA     = q.reg_wdata;
  assign REG_WBE       = q.reg_wbe;
  assign MEM_REQ       = q.mem_req;
  assign MEM_ADDR      = q.mem_addr;
  assign BUSY          = q.busy;
  assign DONE          = q.done;
  assign OP_ADDR       = q.addr;
  assign PC_NEXT       = q.pc;
  assign FAULT_RSVD    = q.fault_rsvd;
  assign FAULT_ILLEGAL = q.fault_ill;
  assign UNPRED        = q.unpred;
  assign UNHANDLED     = q.unhandled;

endmodule // osau_top
